/* tb/aqd_link_properties.sv */
`default_nettype none
module aqd_link_properties
(
  // link signals
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic [aqd_pkg::ADDR_W-1:0] wrAddr,
  input wire logic [aqd_pkg::DATA_W-1:0] wrData,
  input wire logic                       wrStrobe,
  input wire logic                       realign,
  input wire logic                       calibrationActive,
  input wire logic                       outputDataClock,
  input wire logic [aqd_pkg::CODE_W-1:0] dataOut,
  input wire logic                       outOfRange
);
  import aqd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_gain_fill: assert property (
    wrStrobe && wrAddr == ADDR_Q_GAIN |-> wrData[6:0] == 7'h7F)
    else $error("gain write low bits not all ones");
  a_gain_range: assert property (
    wrStrobe && wrAddr == ADDR_Q_GAIN |-> wrData[15:7] inside {[GAIN_REC_MIN:GAIN_REC_MAX]})
    else $error("gain write outside recommended codes");
  a_rsv_d_pattern: assert property (
    wrStrobe && wrAddr == ADDR_RSV_D |-> wrData == PAT_RSV_D)
    else $error("bad word at address D");
  a_rsv_e_pattern: assert property (
    wrStrobe && wrAddr == ADDR_RSV_E |-> wrData == PAT_RSV_E)
    else $error("bad word at address E");
  a_rsv_f_pattern: assert property (
    wrStrobe && wrAddr == ADDR_RSV_F |-> wrData == PAT_RSV_F)
    else $error("bad word at address F");
  // calibration may not be running in the cycle the pulse appears
  a_cal_guard: assert property (
    $rose(realign) |-> !calibrationActive)
    else $error("realign raised during calibration");
  a_pulse_width: assert property (
    $rose(realign) |=> realign)
    else $error("realign pulse too short");
  // first cycle after the fall may still show the cut run phase
  a_clock_held: assert property (
    $fell(realign) |-> ##2 $stable(outputDataClock)[*3])
    else $error("output clock moved while held");
  // two sync stages, one hold cycle, then the fixed latency
  a_restart_bound: assert property (
    $fell(realign) |-> ##5 $changed(outputDataClock))
    else $error("output clock did not restart");
  a_clip_flag: assert property (
    outOfRange |-> dataOut == CODE_MIN || dataOut == CODE_MAX)
    else $error("range flag with unclipped code");
endmodule : aqd_link_properties
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aqd_pkg::*;
  typedef struct {logic signed [VIN_W-1:0] v; logic [OFS_W-1:0] m; logic n;
                  logic [CODE_W-1:0] c; logic o;} aqd_row_type;
  // span 700 mV rows: vin, offset, sign, code, flag
  aqd_row_type rows [7] = '{'{12'sd0, 8'h00, 1'b0, 8'h80, 1'b0},
    '{12'sd0, 8'h00, 1'b1, 8'h7F, 1'b0}, '{12'sd350, 8'h00, 1'b0, 8'hFF, 1'b1},
    '{-12'sd350, 8'h00, 1'b0, 8'h00, 1'b0}, '{-12'sd351, 8'h00, 1'b0, 8'h00, 1'b1},
    '{12'sd349, 8'h00, 1'b0, 8'hFF, 1'b0}, '{12'sd100, 8'h02, 1'b0, 8'hA6, 1'b0}};
  logic                    clk = 1'b0;
  logic                    rst_n, extMode, fsSel, ddrMode, outEdge, calStart;
  logic                    sampleValid, offsetNeg, wrReq, realignReq, reservedOk, realignBusy;
  logic signed [VIN_W-1:0] vinMv;
  logic [OFS_W-1:0]        offsetMag;
  logic [SEL_W-1:0]        wrSel;
  logic [GAIN_W-1:0]       gainCode, gainShadow;
  logic [SPAN_W-1:0]       fullScaleMv;
  int                      numErrors = 0;
  int                      nTests = 0;

  always #4 clk = ~clk;

  aqd_link_if link (.clk(clk), .rst_n(rst_n));
  aqd_device_end aqd_device_end_inst (.link(link), .extendedMode(extMode),
    .fullScaleSelect(fsSel), .ddrMode(ddrMode), .outputEdge(outEdge), .calStart(calStart),
    .vinMv(vinMv), .sampleValid(sampleValid), .offsetMag(offsetMag), .offsetNeg(offsetNeg),
    .fullScaleMv(fullScaleMv), .reservedOk(reservedOk));
  aqd_host_end aqd_host_end_inst (.link(link), .wrReq(wrReq), .wrSel(wrSel),
    .gainCode(gainCode), .realignReq(realignReq), .gainShadow(gainShadow),
    .realignBusy(realignBusy));
  aqd_link_properties aqd_link_properties_inst (.clk(clk), .rst_n(rst_n),
    .wrAddr(link.wrAddr), .wrData(link.wrData), .wrStrobe(link.wrStrobe),
    .realign(link.realign), .calibrationActive(link.calibrationActive),
    .outputDataClock(link.outputDataClock), .dataOut(link.dataOut),
    .outOfRange(link.outOfRange));

  task automatic giveVerdict();
    if (numErrors == 0 && nTests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : giveVerdict

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic convert(input logic signed [VIN_W-1:0] v, input logic [OFS_W-1:0] m,
                         input logic n);
    vinMv = v;
    offsetMag = m;
    offsetNeg = n;
    sampleValid = 1'b1;
    tick();
    sampleValid = 1'b0;
  endtask : convert

  task automatic hostWrite(input logic [SEL_W-1:0] s, input logic [GAIN_W-1:0] g);
    wrSel = s;
    gainCode = g;
    wrReq = 1'b1;
    tick();
    wrReq = 1'b0;
    tick(4);
  endtask : hostWrite

  // bounded wait; a hang ends the run as a mismatch
  task automatic waitIdle();
    int k;
    k = 0;
    while (realignBusy !== 1'b0 && k < 300)
    begin
      tick();
      k++;
    end
    if (k == 300)
    begin
      numErrors++;
      giveVerdict();
    end
  endtask : waitIdle

  task automatic realignLevel(input logic d, input logic e);
    int   k;
    logic c0;
    ddrMode = d;
    outEdge = e;
    tick(4);
    realignReq = 1'b1;
    tick();
    realignReq = 1'b0;
    k = 0;
    while (link.realign !== 1'b1 && k < 10)
    begin
      tick();
      k++;
    end
    if (k == 10)
    begin
      numErrors++;
      giveVerdict();
    end
    tick(4);
    check("heldLevel", 16'(link.outputDataClock), 16'(d ? e : !e));
    waitIdle();
    tick(12);
    // running again: one toggle per half period
    c0 = link.outputDataClock;
    tick(d ? 2 : 1);
    check("clockToggle", 16'(link.outputDataClock), 16'(!c0));
  endtask : realignLevel

  initial
  begin
    {rst_n, fsSel, ddrMode, outEdge, calStart, sampleValid, offsetNeg, wrReq} = '0;
    {realignReq, vinMv, offsetMag, wrSel, gainCode} = '0;
    extMode = 1'b1;
    tick(8);
    rst_n = 1'b1;
    tick(2);
    check("gainShadow", 16'(gainShadow), 16'h0100);
    check("fullScaleMv", 16'(fullScaleMv), 16'h02BC);
    foreach (rows[i])
    begin
      convert(rows[i].v, rows[i].m, rows[i].n);
      check("dataOut", 16'(link.dataOut), 16'(rows[i].c));
      check("outOfRange", 16'(link.outOfRange), 16'(rows[i].o));
    end
    hostWrite(2'h0, 9'h1FF);
    check("gainShadow", 16'(gainShadow), 16'h01C0);
    check("fullScaleMv", 16'(fullScaleMv), 16'h0325);
    convert(12'sd350, 8'h00, 1'b0);
    check("dataOut", 16'(link.dataOut), 16'h00EF);
    hostWrite(2'h0, 9'h000);
    check("fullScaleMv", 16'(fullScaleMv), 16'h0299);
    for (int s = 1; s < 4; s++)
      hostWrite(SEL_W'(s), 9'h000);
    check("reservedOk", 16'(reservedOk), 16'h0001);
    extMode = 1'b0;
    fsSel = 1'b1;
    hostWrite(2'h0, 9'h100);
    check("fullScaleMv", 16'(fullScaleMv), 16'h0366);
    fsSel = 1'b0;
    tick(3);
    check("fullScaleMv", 16'(fullScaleMv), 16'h028A);
    extMode = 1'b1;
    tick(3);
    check("fullScaleMv", 16'(fullScaleMv), 16'h0299);
    for (int i = 0; i < 4; i++)
      realignLevel(i[1], i[0]);
    // realign asked for just after calibration starts
    calStart = 1'b1;
    tick();
    calStart = 1'b0;
    realignReq = 1'b1;
    tick();
    realignReq = 1'b0;
    tick(20);
    check("realign", 16'(link.realign), 16'h0000);
    check("realignBusy", 16'(realignBusy), 16'h0001);
    check("calActive", 16'(link.calibrationActive), 16'h0001);
    waitIdle();
    check("calActive", 16'(link.calibrationActive), 16'h0000);
    tick(12);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(2);
    check("gainShadow", 16'(gainShadow), 16'h0100);
    check("fullScaleMv", 16'(fullScaleMv), 16'h02BC);
    check("dataOut", 16'(link.dataOut), 16'h0000);
    giveVerdict();
  end
endmodule : tb
`default_nettype wire

/* verilog/aqd_device_end.sv */
// Overview of operation
// [R1] gain word bits 15:7 set q span
// [R2] span linear: 560, 700, 840 mV
// [R3] host keeps gain in recommended range
// [R4] new gain applies without calibration
// [R5] gain resets to midscale code
// [R6] host fills low seven bits with ones
// [R7] reserved d written as 0x3FFF
// [R8] reserved e written as 0x07FF
// [R9] reserved f written as 0x007F
// [R10] positive and negative zero offset differ
// [R11] realign pulse resets output clock phase
// [R12] host holds pulse minimum width, clocked release
// [R13] pulse accepted anytime, output clock held
// [R14] held level by mode and edge
// [R15] release aligns on next clock edge
// [R16] clock restarts after fixed latency
// [R17] no realign while calibration active
// [R18] in-range inputs give 8-bit codes
// [R19] overrange saturates and flags out of range
// [R20] flag high while code beyond 00h..FFh
// [R21] adjust only in extended control mode
// [R22] registers write-only, no readback
`default_nettype none
module aqd_device_end
(
  // link
  aqd_link_if.device                      link,
  // mode pins
  input  wire logic                       extendedMode,
  input  wire logic                       fullScaleSelect,
  input  wire logic                       ddrMode,
  input  wire logic                       outputEdge,
  input  wire logic                       calStart,
  // sample and offset
  input  wire logic signed [aqd_pkg::VIN_W-1:0] vinMv,
  input  wire logic                       sampleValid,
  input  wire logic [aqd_pkg::OFS_W-1:0]  offsetMag,
  input  wire logic                       offsetNeg,
  // status
  output logic [aqd_pkg::SPAN_W-1:0]      fullScaleMv,
  output logic                            reservedOk
);
  import aqd_pkg::*;

  logic [GAIN_W-1:0] qGainReg;
  logic [GAIN_W-1:0] qGainNext;
  logic [2:0]        rsvOkReg;
  logic [2:0]        rsvOkNext;
  logic [SPAN_W-1:0] spanReg;
  logic [SPAN_W-1:0] spanNext;
  logic [CODE_W-1:0] dataReg;
  logic [CODE_W-1:0] dataNext;
  logic              oorReg;
  logic              oorNext;
  logic              realignMeta;
  logic              realignSync;
  aqd_state_type     stateReg;
  aqd_state_type     stateNext;
  logic              clkOutReg;
  logic              clkOutNext;
  logic [CNT_W-1:0]  phaseReg;
  logic [CNT_W-1:0]  phaseNext;
  logic [CNT_W-1:0]  latReg;
  logic [CNT_W-1:0]  latNext;
  logic [CNT_W-1:0]  calReg;
  logic [CNT_W-1:0]  calNext;
  logic [CNT_W-1:0]  halfCyc;
  logic              holdLevel;

  // offset in tenths; negative zero sits one tenth below positive zero
  function automatic int offsetTenths(input logic [OFS_W-1:0] mag, input logic neg);
    int base;
    base = int'(mag) * TENTHS_PER_LSB;
    return neg ? -(base + 1) : base; // [R10]
  endfunction : offsetTenths

  function automatic int convTenths
  (
    input logic signed [VIN_W-1:0] vin,
    input logic [SPAN_W-1:0]       span
  );
    int scaled;
    scaled = (int'(vin) * CODE_TOP_TENTHS) / int'(span);
    return CODE_MID_TENTHS + scaled;
  endfunction : convTenths

  // register writes; only accepted in extended mode, nothing reads back
  always_comb
  begin
    qGainNext = qGainReg;
    rsvOkNext = rsvOkReg;
    if (link.wrStrobe && extendedMode) // [R21]
    begin
      case (link.wrAddr)
        ADDR_Q_GAIN: qGainNext = link.wrData[DATA_W-1:GAIN_LSB]; // [R1]
        ADDR_RSV_D:  rsvOkNext[0] = (link.wrData == PAT_RSV_D);
        ADDR_RSV_E:  rsvOkNext[1] = (link.wrData == PAT_RSV_E);
        ADDR_RSV_F:  rsvOkNext[2] = (link.wrData == PAT_RSV_F);
        default:     qGainNext = qGainReg; // [R22]
      endcase
    end
  end

  // span follows gain the next cycle in extended mode, no calibration step needed
  always_comb
  begin
    if (extendedMode)
    begin
      spanNext = gainSpanMv(qGainReg); // [R2] [R4]
    end
    else
    begin
      spanNext = fullScaleSelect ? SPAN_NE_HIGH : SPAN_NE_LOW; // [R21]
    end
  end

  // conversion with clipping
  always_comb
  begin
    int acc;
    acc      = 0;
    dataNext = dataReg;
    oorNext  = oorReg;
    if (sampleValid)
    begin
      acc = convTenths(vinMv, spanReg) + offsetTenths(offsetMag, offsetNeg);
      if (acc < 0)
      begin
        dataNext = CODE_MIN; // [R19]
        oorNext  = 1'b1; // [R20]
      end
      else if (acc >= CODE_TOP_TENTHS)
      begin
        dataNext = CODE_MAX; // [R19]
        oorNext  = 1'b1; // [R20]
      end
      else
      begin
        dataNext = CODE_W'(acc / TENTHS_PER_LSB); // [R18]
        oorNext  = 1'b0;
      end
    end
  end

  // output clock divider and realignment
  always_comb
  begin
    halfCyc    = ddrMode ? HALF_DDR : HALF_SDR;
    holdLevel  = ddrMode ? outputEdge : ~outputEdge; // [R14]
    stateNext  = stateReg;
    clkOutNext = clkOutReg;
    phaseNext  = phaseReg;
    latNext    = latReg;
    case (stateReg)
      ST_RUN:
      begin
        if (realignSync)
        begin
          // abrupt hold can cut the current phase short
          stateNext  = ST_HOLD; // [R13]
          clkOutNext = holdLevel; // [R14]
        end
        else if (phaseReg == halfCyc - 8'h01)
        begin
          phaseNext  = '0;
          clkOutNext = ~clkOutReg;
        end
        else
        begin
          phaseNext = phaseReg + 8'h01;
        end
      end
      ST_HOLD:
      begin
        clkOutNext = holdLevel; // [R13]
        if (!realignSync)
        begin
          stateNext = ST_LATENCY; // [R15]
          latNext   = T_AD_CYC - 8'h01;
          phaseNext = '0; // [R11]
        end
      end
      ST_LATENCY:
      begin
        clkOutNext = holdLevel;
        if (realignSync)
        begin
          stateNext = ST_HOLD;
        end
        else if (latReg == '0)
        begin
          stateNext  = ST_RUN; // [R16]
          clkOutNext = ~holdLevel;
          phaseNext  = '0;
        end
        else
        begin
          latNext = latReg - 8'h01;
        end
      end
      default:
      begin
        stateNext  = ST_RUN;
        clkOutNext = holdLevel;
        phaseNext  = '0;
      end
    endcase
  end

  // calibration timer; realign during it is the host's duty to avoid
  always_comb
  begin
    calNext = calReg;
    if (calReg != '0)
    begin
      calNext = calReg - 8'h01;
    end
    else if (calStart)
    begin
      calNext = CAL_CYC; // [R17]
    end
  end

  always_ff @(posedge link.clk)
  begin
    if (!link.rst_n)
    begin
      qGainReg    <= RST_Q_GAIN[DATA_W-1:GAIN_LSB]; // [R5]
      rsvOkReg    <= RSV_OK_RST;
      spanReg     <= SPAN_NE_LOW;
      dataReg     <= CODE_MIN;
      oorReg      <= 1'b0;
      realignMeta <= 1'b0;
      realignSync <= 1'b0;
      stateReg    <= ST_RUN;
      clkOutReg   <= 1'b0;
      phaseReg    <= '0;
      latReg      <= '0;
      calReg      <= '0;
    end
    else
    begin
      qGainReg    <= qGainNext;
      rsvOkReg    <= rsvOkNext;
      spanReg     <= spanNext;
      dataReg     <= dataNext;
      oorReg      <= oorNext;
      realignMeta <= link.realign; // [R13]
      realignSync <= realignMeta;
      stateReg    <= stateNext;
      clkOutReg   <= clkOutNext;
      phaseReg    <= phaseNext;
      latReg      <= latNext;
      calReg      <= calNext;
    end
  end

  assign link.dataOut           = dataReg;
  assign link.outOfRange        = oorReg;
  assign link.outputDataClock   = clkOutReg;
  assign link.calibrationActive = (calReg != '0);
  assign fullScaleMv            = spanReg;
  assign reservedOk             = &rsvOkReg;
endmodule : aqd_device_end
`default_nettype wire

/* verilog/aqd_host_end.sv */
`default_nettype none
module aqd_host_end
(
  // link
  aqd_link_if.host                        link,
  // write requests
  input  wire logic                       wrReq,
  input  wire logic [aqd_pkg::SEL_W-1:0]  wrSel,
  input  wire logic [aqd_pkg::GAIN_W-1:0] gainCode,
  // realign request
  input  wire logic                       realignReq,
  // status
  output logic [aqd_pkg::GAIN_W-1:0]      gainShadow,
  output logic                            realignBusy
);
  import aqd_pkg::*;

  logic [ADDR_W-1:0]   addrReg;
  logic [ADDR_W-1:0]   addrNext;
  logic [DATA_W-1:0]   dataReg;
  logic [DATA_W-1:0]   dataNext;
  logic                strobeReg;
  logic                strobeNext;
  logic [GAIN_W-1:0]   shadowReg;
  logic [GAIN_W-1:0]   shadowNext;
  aqd_host_state_type  stateReg;
  aqd_host_state_type  stateNext;
  logic                pulseReg;
  logic                pulseNext;
  logic [CNT_W-1:0]    cntReg;
  logic [CNT_W-1:0]    cntNext;
  logic [GAIN_W-1:0]   gainSafe;

  function automatic logic [GAIN_W-1:0] clampGain(input logic [GAIN_W-1:0] code);
    if (code < GAIN_REC_MIN)
    begin
      return GAIN_REC_MIN;
    end
    else if (code > GAIN_REC_MAX)
    begin
      return GAIN_REC_MAX;
    end
    return code;
  endfunction : clampGain

  // device has no readback, so the shadow is the only copy
  always_comb
  begin
    gainSafe   = clampGain(gainCode); // [R3]
    addrNext   = addrReg;
    dataNext   = dataReg;
    shadowNext = shadowReg;
    strobeNext = wrReq;
    if (wrReq)
    begin
      case (wrSel)
        2'h0:
        begin
          addrNext   = ADDR_Q_GAIN;
          dataNext   = {gainSafe, GAIN_FILL}; // [R6]
          shadowNext = gainSafe; // [R22]
        end
        2'h1:
        begin
          addrNext = ADDR_RSV_D;
          dataNext = PAT_RSV_D; // [R7]
        end
        2'h2:
        begin
          addrNext = ADDR_RSV_E;
          dataNext = PAT_RSV_E; // [R8]
        end
        default:
        begin
          addrNext = ADDR_RSV_F;
          dataNext = PAT_RSV_F; // [R9]
        end
      endcase
    end
  end

  always_comb
  begin
    stateNext = stateReg;
    pulseNext = pulseReg;
    cntNext   = cntReg;
    case (stateReg)
      H_IDLE:
      begin
        if (realignReq)
        begin
          stateNext = H_WAIT;
        end
      end
      H_WAIT:
      begin
        if (!link.calibrationActive) // [R17]
        begin
          stateNext = H_PULSE;
          pulseNext = 1'b1;
          cntNext   = RST_MIN_CYC - 8'h01;
        end
      end
      H_PULSE:
      begin
        if (cntReg == '0)
        begin
          stateNext = H_IDLE;
          pulseNext = 1'b0; // [R12]
        end
        else
        begin
          cntNext = cntReg - 8'h01;
        end
      end
      default:
      begin
        stateNext = H_IDLE;
        pulseNext = 1'b0;
      end
    endcase
  end

  always_ff @(posedge link.clk)
  begin
    if (!link.rst_n)
    begin
      addrReg   <= '0;
      dataReg   <= '0;
      strobeReg <= 1'b0;
      shadowReg <= GAIN_MID;
      stateReg  <= H_IDLE;
      pulseReg  <= 1'b0;
      cntReg    <= '0;
    end
    else
    begin
      addrReg   <= addrNext;
      dataReg   <= dataNext;
      strobeReg <= strobeNext;
      shadowReg <= shadowNext;
      stateReg  <= stateNext;
      pulseReg  <= pulseNext;
      cntReg    <= cntNext;
    end
  end

  assign link.wrAddr   = addrReg;
  assign link.wrData   = dataReg;
  assign link.wrStrobe = strobeReg;
  assign link.realign  = pulseReg;
  assign gainShadow    = shadowReg;
  assign realignBusy   = (stateReg != H_IDLE);
endmodule : aqd_host_end
`default_nettype wire

/* verilog/aqd_link_if.sv */
`default_nettype none
interface aqd_link_if
(
  input wire logic clk,
  input wire logic rst_n
);
  logic [aqd_pkg::ADDR_W-1:0] wrAddr;
  logic [aqd_pkg::DATA_W-1:0] wrData;
  logic                       wrStrobe;
  logic                       realign;
  logic                       calibrationActive;
  logic                       outputDataClock;
  logic [aqd_pkg::CODE_W-1:0] dataOut;
  logic                       outOfRange;

  modport device
  (
    input  clk, rst_n, wrStrobe, wrAddr, wrData, realign,
    output calibrationActive, outputDataClock, dataOut, outOfRange
  );

  modport host
  (
    input  clk, rst_n, calibrationActive, outputDataClock, dataOut, outOfRange,
    output wrStrobe, wrAddr, wrData, realign
  );
endinterface : aqd_link_if
`default_nettype wire

/* verilog/aqd_pkg.sv */
`default_nettype none
package aqd_pkg;
  // widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int GAIN_W = 9;
  localparam int CODE_W = 8;
  localparam int VIN_W  = 12;
  localparam int SPAN_W = 10;
  localparam int OFS_W  = 8;
  localparam int CNT_W  = 8;
  localparam int SEL_W  = 2;

  // register map
  localparam logic [ADDR_W-1:0] ADDR_Q_GAIN = 4'hB;
  localparam logic [ADDR_W-1:0] ADDR_RSV_D  = 4'hD;
  localparam logic [ADDR_W-1:0] ADDR_RSV_E  = 4'hE;
  localparam logic [ADDR_W-1:0] ADDR_RSV_F  = 4'hF;

  // field layout and fixed patterns
  localparam int                GAIN_LSB    = 7;
  localparam logic [6:0]        GAIN_FILL   = 7'h7F;
  localparam logic [DATA_W-1:0] RST_Q_GAIN  = 16'h807F;
  localparam logic [DATA_W-1:0] PAT_RSV_D   = 16'h3FFF;
  localparam logic [DATA_W-1:0] PAT_RSV_E   = 16'h07FF;
  localparam logic [DATA_W-1:0] PAT_RSV_F   = 16'h007F;
  localparam logic [2:0]        RSV_OK_RST  = 3'h7;

  // gain codes
  localparam logic [GAIN_W-1:0] GAIN_MID     = 9'h100;
  localparam logic [GAIN_W-1:0] GAIN_FULL    = 9'h1FF;
  localparam logic [GAIN_W-1:0] GAIN_REC_MIN = 9'h0C0;
  localparam logic [GAIN_W-1:0] GAIN_REC_MAX = 9'h1C0;

  // spans in mV
  localparam logic [SPAN_W-1:0] SPAN_MIN_MV   = 10'h230;
  localparam logic [SPAN_W-1:0] SPAN_RANGE_MV = 10'h118;
  localparam logic [SPAN_W-1:0] SPAN_NE_HIGH  = 10'h366;
  localparam logic [SPAN_W-1:0] SPAN_NE_LOW   = 10'h28A;

  // output codes, tenths of an lsb
  localparam logic [CODE_W-1:0] CODE_MIN         = 8'h00;
  localparam logic [CODE_W-1:0] CODE_MAX         = 8'hFF;
  localparam int                TENTHS_PER_LSB   = 10;
  localparam int                CODE_MID_TENTHS  = 1280;
  localparam int                CODE_TOP_TENTHS  = 2560;

  // timing
  localparam int              CLK_PERIOD_NS   = 8;
  localparam int              T_AD_NS         = 16;
  localparam int              RST_MIN_NS      = 16;
  localparam logic [CNT_W-1:0] T_AD_CYC   = CNT_W'((T_AD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RST_MIN_CYC =
    CNT_W'((RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CAL_CYC    = 8'h40;
  localparam logic [CNT_W-1:0] HALF_SDR   = 8'h01;
  localparam logic [CNT_W-1:0] HALF_DDR   = 8'h02;

  typedef enum logic [1:0]
  {
    ST_RUN     = 2'b00,
    ST_HOLD    = 2'b01,
    ST_LATENCY = 2'b11
  } aqd_state_type;

  typedef enum logic [1:0]
  {
    H_IDLE  = 2'b00,
    H_WAIT  = 2'b01,
    H_PULSE = 2'b11
  } aqd_host_state_type;

  // span = 560 + code * 280 / 511
  function automatic logic [SPAN_W-1:0] gainSpanMv(input logic [GAIN_W-1:0] code);
    int prod;
    prod = int'(code) * int'(SPAN_RANGE_MV) / int'(GAIN_FULL);
    return SPAN_MIN_MV + SPAN_W'(prod);
  endfunction : gainSpanMv
endpackage : aqd_pkg
`default_nettype wire
